/* File: skip_exec_regs.svh */
// Constants for the skip and logic move execution datapath
`ifndef SKIP_EXEC_REGS_SVH
`define SKIP_EXEC_REGS_SVH
`define DW 8
`define AW 7
`define OPW 3
`define ACC_RST 8'h00
`define ZERO_RST 1'b0
`define ADDR_RST 7'h00
`define PULSE_RST 1'b0
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1
`endif

/* File: skip_exec_pkg.sv */
// Types for the skip and logic move execution datapath
package skip_exec_pkg;
  typedef enum logic [2:0] {
    OP_DEC_SKIP = 3'h0,
    OP_INC_SKIP = 3'h1,
    OP_OR_LIT = 3'h2,
    OP_LOAD_LIT = 3'h3,
    OP_OR_FILE = 3'h4,
    OP_STORE = 3'h5,
    OP_NONE = 3'h7
  } op_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'h1,
    ST_SQUASH = 2'h2
  } state_t;
endpackage

/* File: skip_exec_alu.sv */
// Combinational result unit for the execution datapath
`timescale 1ns/1ps
`include "skip_exec_regs.svh"
module skip_exec_alu (
  input wire skip_exec_pkg::op_t i_op,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_file,
  input wire logic [7:0] i_lit,
  output logic [7:0] o_result
);
  always_comb begin
    case (i_op)
      skip_exec_pkg::OP_DEC_SKIP: o_result = i_file - `BYTE_ONE;
      skip_exec_pkg::OP_INC_SKIP: o_result = i_file + `BYTE_ONE;
      skip_exec_pkg::OP_OR_LIT: o_result = i_acc | i_lit;
      skip_exec_pkg::OP_LOAD_LIT: o_result = i_lit;
      skip_exec_pkg::OP_OR_FILE: o_result = i_acc | i_file;
      skip_exec_pkg::OP_STORE: o_result = i_acc;
      default: o_result = `BYTE_ZERO;
    endcase
  end
endmodule

/* File: skip_exec.sv */
// Execution datapath for skip, OR, literal load and store instructions
`timescale 1ns/1ps
`include "skip_exec_regs.svh"
module skip_exec (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_valid,
  input wire skip_exec_pkg::op_t i_op,
  input wire logic i_dest,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_lit,
  input wire logic [7:0] i_file_rdata,
  output logic [7:0] o_acc,
  output logic o_zero,
  output logic o_file_we,
  output logic [6:0] o_file_addr,
  output logic [7:0] o_file_wdata,
  output logic o_squashed,
  output logic o_retired
);
  // ------------------------------------------------------------
  // Result and decode
  // ------------------------------------------------------------
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == `BYTE_ZERO);
  endfunction

  logic [7:0] acc_q;
  logic zero_q;
  logic file_we_q;
  logic [6:0] file_addr_q;
  logic [7:0] file_wdata_q;
  logic squashed_q;
  logic retired_q;
  skip_exec_pkg::state_t state_q;
  logic [7:0] result;
  logic exec;
  logic is_skip;
  logic to_file;
  logic to_acc;
  logic sets_zero;

  skip_exec_alu u_alu (
    .i_op(i_op),
    .i_acc(acc_q),
    .i_file(i_file_rdata),
    .i_lit(i_lit),
    .o_result(result)
  );

  // An instruction in the squash slot is dropped whole
  assign exec = i_valid && (state_q == skip_exec_pkg::ST_RUN);
  assign is_skip = (i_op == skip_exec_pkg::OP_DEC_SKIP) ||
                   (i_op == skip_exec_pkg::OP_INC_SKIP);
  assign to_file = exec && ((i_op == skip_exec_pkg::OP_STORE) ||
                   ((is_skip || i_op == skip_exec_pkg::OP_OR_FILE) &&
                    i_dest == `DEST_FILE));
  assign to_acc = exec && ((i_op == skip_exec_pkg::OP_OR_LIT) ||
                  (i_op == skip_exec_pkg::OP_LOAD_LIT) ||
                  ((is_skip || i_op == skip_exec_pkg::OP_OR_FILE) &&
                   i_dest == `DEST_ACC));
  assign sets_zero = exec && ((i_op == skip_exec_pkg::OP_OR_LIT) ||
                     (i_op == skip_exec_pkg::OP_OR_FILE));

  // ------------------------------------------------------------
  // Accumulator
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_q <= `ACC_RST;
    end else if (to_acc) begin
      acc_q <= result;
    end
  end

  // ------------------------------------------------------------
  // Zero flag
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      zero_q <= `ZERO_RST;
    end else if (sets_zero) begin
      zero_q <= is_zero(result);
    end
  end

  // ------------------------------------------------------------
  // File register write port
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      file_we_q <= `PULSE_RST;
      file_addr_q <= `ADDR_RST;
      file_wdata_q <= `BYTE_ZERO;
    end else begin
      file_we_q <= to_file;
      if (to_file) begin
        file_addr_q <= i_addr;
        file_wdata_q <= result;
      end
    end
  end

  // ------------------------------------------------------------
  // Skip control
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= skip_exec_pkg::ST_RUN;
      squashed_q <= `PULSE_RST;
      retired_q <= `PULSE_RST;
    end else begin
      retired_q <= exec;
      squashed_q <= i_valid && (state_q == skip_exec_pkg::ST_SQUASH);
      case (state_q)
        skip_exec_pkg::ST_RUN: begin
          if (exec && is_skip && is_zero(result)) begin
            state_q <= skip_exec_pkg::ST_SQUASH;
          end
        end
        skip_exec_pkg::ST_SQUASH: begin
          if (i_valid) begin
            state_q <= skip_exec_pkg::ST_RUN;
          end
        end
        default: state_q <= skip_exec_pkg::ST_RUN;
      endcase
    end
  end

  assign o_acc = acc_q;
  assign o_zero = zero_q;
  assign o_file_we = file_we_q;
  assign o_file_addr = file_addr_q;
  assign o_file_wdata = file_wdata_q;
  assign o_squashed = squashed_q;
  assign o_retired = retired_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_zero_skip;
    i_valid && state_q == skip_exec_pkg::ST_RUN && is_skip &&
      is_zero(result);
  endsequence
  sequence s_next_dropped;
    i_valid ##1 o_squashed && !o_retired;
  endsequence

  AST_DEC_ROUTE: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    exec && i_op == skip_exec_pkg::OP_DEC_SKIP && i_dest == `DEST_ACC
    |=> o_acc == $past(i_file_rdata) - `BYTE_ONE && $stable(o_zero))
    else $error("decrement result not routed to accumulator");
  AST_DEC_SKIP: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    s_zero_skip ##1 s_next_dropped |-> $stable(o_acc))
    else $error("squashed instruction changed accumulator");
  AST_INC_FILE: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    exec && i_op == skip_exec_pkg::OP_INC_SKIP && i_dest == `DEST_FILE
    |=> o_file_we && o_file_wdata == $past(i_file_rdata) + `BYTE_ONE)
    else $error("increment result not written to file");
  AST_SKIP_STATE: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    exec && is_skip |=> (state_q == skip_exec_pkg::ST_SQUASH) ==
      ($past(result) == `BYTE_ZERO))
    else $error("skip decision wrong");
  AST_OR_LIT: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    exec && i_op == skip_exec_pkg::OP_OR_LIT
    |=> o_acc == ($past(acc_q) | $past(i_lit)))
    else $error("or literal wrong");
  AST_LOAD: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    exec && i_op == skip_exec_pkg::OP_LOAD_LIT
    |=> o_acc == $past(i_lit) && $stable(o_zero) && !o_file_we)
    else $error("load literal wrong");
  AST_OR_FILE: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    exec && i_op == skip_exec_pkg::OP_OR_FILE && i_dest == `DEST_FILE
    |=> o_file_we && o_file_wdata == ($past(acc_q) | $past(i_file_rdata)))
    else $error("or with file wrong");
  AST_STORE: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    exec && i_op == skip_exec_pkg::OP_STORE
    |=> o_file_we && o_file_addr == $past(i_addr) &&
        o_file_wdata == $past(acc_q) && $stable(o_zero))
    else $error("store wrong");
  AST_ZERO: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    sets_zero |=> o_zero == (o_file_we ? o_file_wdata == `BYTE_ZERO :
      o_acc == `BYTE_ZERO))
    else $error("zero flag wrong");
  AST_DEC_FILE: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    exec && i_op == skip_exec_pkg::OP_DEC_SKIP && i_dest == `DEST_FILE
    |=> o_file_we && o_file_wdata == $past(i_file_rdata) - `BYTE_ONE &&
        $stable(o_acc) && $stable(o_zero))
    else $error("decrement result not written to file");
  AST_INC_ACC: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    exec && i_op == skip_exec_pkg::OP_INC_SKIP && i_dest == `DEST_ACC
    |=> o_acc == $past(i_file_rdata) + `BYTE_ONE && !o_file_we &&
        $stable(o_zero))
    else $error("increment result not routed to accumulator");
  AST_SQUASH_QUIET: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    i_valid && state_q == skip_exec_pkg::ST_SQUASH
    |=> o_squashed && !o_retired && !o_file_we && $stable(o_acc) &&
        $stable(o_zero))
    else $error("squashed instruction left a trace");
endmodule

/* File: skip_exec_tb.sv */
// Self-checking testbench for the skip and logic move execution datapath
`timescale 1ns/1ps
module skip_exec_tb;
  logic i_clk, i_arst_n, i_valid, i_dest;
  skip_exec_pkg::op_t i_op;
  logic [6:0] i_addr, o_file_addr, wa;
  logic [7:0] i_lit, i_file_rdata, o_acc, o_file_wdata;
  logic o_zero, o_file_we, o_squashed, o_retired;
  logic [7:0] mem [128];
  logic [7:0] m_acc, res, wd;
  logic m_zero, pend, e_we, e_sq, e_ret;
  int error_cnt, checked;

  // File register content as seen in the issuing cycle
  assign i_file_rdata = mem[i_addr];

  skip_exec dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_valid(i_valid),
    .i_op(i_op), .i_dest(i_dest), .i_addr(i_addr), .i_lit(i_lit),
    .i_file_rdata(i_file_rdata), .o_acc(o_acc), .o_zero(o_zero),
    .o_file_we(o_file_we), .o_file_addr(o_file_addr),
    .o_file_wdata(o_file_wdata), .o_squashed(o_squashed),
    .o_retired(o_retired));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Drives one cycle, steps the model, checks the registered answer
  task automatic issue(input logic v, input logic [2:0] op, input logic d,
                       input logic [6:0] a, input logic [7:0] k);
    i_valid = v;
    i_op = skip_exec_pkg::op_t'(op);
    i_dest = d;
    i_addr = a;
    i_lit = k;
    e_we = 1'b0;
    e_sq = 1'b0;
    e_ret = 1'b0;
    if (v && pend) begin
      pend = 1'b0;
      e_sq = 1'b1;
    end else if (v) begin
      e_ret = 1'b1;
      res = m_acc | mem[a];
      if (op == 3'h0) res = mem[a] - 8'h01;
      if (op == 3'h1) res = mem[a] + 8'h01;
      if (op < 3'h2) pend = (res == 8'h00);
      if (op == 3'h4) m_zero = (res == 8'h00);
      if (op == 3'h2) m_acc = m_acc | k;
      if (op == 3'h2) m_zero = (m_acc == 8'h00);
      if (op == 3'h3) m_acc = k;
      if (op == 3'h5) res = m_acc;
      if (op == 3'h0 || op == 3'h1 || op == 3'h4) begin
        if (d) e_we = 1'b1;
        else m_acc = res;
      end
      if (op == 3'h5) e_we = 1'b1;
      wa = a;
      wd = res;
    end
    @(posedge i_clk);
    #1;
    if (e_we) mem[wa] = wd;
    chk({7'h00, o_retired}, {7'h00, e_ret});
    chk({7'h00, o_squashed}, {7'h00, e_sq});
    chk(o_acc, m_acc);
    chk({7'h00, o_zero}, {7'h00, m_zero});
    chk({7'h00, o_file_we}, {7'h00, e_we});
    if (e_we) chk({1'b0, o_file_addr}, {1'b0, wa});
    if (e_we) chk(o_file_wdata, wd);
  endtask

  initial begin
    logic [6:0] a;
    i_arst_n = 1'b0;
    i_valid = 1'b0;
    i_op = skip_exec_pkg::OP_NONE;
    i_dest = 1'b0;
    i_addr = 7'h00;
    i_lit = 8'h00;
    m_acc = 8'h00;
    m_zero = 1'b0;
    pend = 1'b0;
    error_cnt = 0;
    checked = 0;
    for (int n = 0; n < 128; n++) mem[n] = 8'h00;
    void'($urandom(32'h8454));
    repeat (3) @(posedge i_clk);
    #1;
    i_arst_n = 1'b1;
    mem[5] = 8'h01;
    mem[6] = 8'hFF;
    issue(1'b1, 3'h0, 1'b0, 7'h05, 8'h00);
    issue(1'b1, 3'h5, 1'b0, 7'h09, 8'h00);
    issue(1'b1, 3'h1, 1'b1, 7'h06, 8'h00);
    issue(1'b0, 3'h3, 1'b0, 7'h00, 8'h11);
    issue(1'b1, 3'h3, 1'b0, 7'h00, 8'h55);
    issue(1'b1, 3'h3, 1'b0, 7'h00, 8'h00);
    issue(1'b1, 3'h2, 1'b0, 7'h00, 8'h00);
    issue(1'b1, 3'h2, 1'b0, 7'h00, 8'hFF);
    issue(1'b1, 3'h4, 1'b1, 7'h06, 8'h00);
    issue(1'b1, 3'h7, 1'b0, 7'h06, 8'h00);
    for (int n = 0; n < 2000; n++) begin
      a = 7'($urandom_range(0, 7));
      case ($urandom_range(0, 4))
        0: mem[a] = 8'h01;
        1: mem[a] = 8'hFF;
        2: mem[a] = 8'($urandom);
        default: ;
      endcase
      issue(1'($urandom_range(0, 5) != 0), 3'($urandom_range(0, 5)),
            1'($urandom), a, 8'($urandom));
    end
    stop_test();
  end

  initial begin
    #15000;
    error_cnt++;
    stop_test();
  end
endmodule
